//--- rtl/psw_defs.vh
`ifndef PSW_DEFS_VH
`define PSW_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PSW_ADDR_CTRL      8'h00
`define PSW_ADDR_STATUS    8'h04
`define PSW_ADDR_SLEW      8'h08
`define PSW_ADDR_TEMP      8'h0c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PSW_CTRL_SERIES_ON 0
`define PSW_CTRL_RESET     2'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define PSW_ST_TROUBLE     0
`define PSW_ST_ALARM       1
`define PSW_ST_SHORT       2
`define PSW_ST_HOT         3
`define PSW_ST_COMBINED    4
`define PSW_ST_SLEW_FROZEN 5
`define PSW_ST_SWITCH      6
`define PSW_ST_STATE_LO    7

// ----------------------------------------
// Slew codes (V/ns)
// ----------------------------------------
`define PSW_SLEW_MIN       8'h1e
`define PSW_SLEW_MAX       8'h96
`define PSW_SLEW_RAIL      8'h64

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSW_CLK_HZ         10000000
`define PSW_DUTY_HZ        9000
`define PSW_DUTY_CYCLES    (`PSW_CLK_HZ / `PSW_DUTY_HZ)
`define PSW_FILT_BITS      6
`define PSW_SHORT_RST_US   200
`define PSW_SHORT_RST_CYC  (`PSW_SHORT_RST_US * (`PSW_CLK_HZ / 1000000))

// ----------------------------------------
// Temperature to duty (per mille)
// ----------------------------------------
`define PSW_DUTY_FLOOR     10'h00a
`define PSW_DUTY_LO        10'h01e
`define PSW_DUTY_HI        10'h334
`define PSW_TEMP_LO        8'h19
`define PSW_TEMP_HI        8'h96
`define PSW_HOT_HYST       8'h0a

// ----------------------------------------
// Diode emulation states
// ----------------------------------------
`define PSW_DE_WAIT_POS    3'h1
`define PSW_DE_WAIT_NEG    3'h2
`define PSW_DE_ASSIST      3'h3
`define PSW_DE_LOCKED      3'h4
`define PSW_DE_CMD_ON      3'h5

`endif

//--- rtl/psw_top.v
// How it works
// [RULE1] Fault pins encode lockout/heat, overcurrent, short
// [RULE2] Trouble low until series switch on
// [RULE3] Lockout or heat disables switch, trouble low
// [RULE4] Trouble low while slew pin open
// [RULE5] Short or heat: trouble low until cleared
// [RULE6] Alarm low on short or overcurrent
// [RULE7] Alarm grounded at power-up: combine on trouble
// [RULE8] Protection acts regardless of fault pin use
// [RULE9] Slew strength from pin resistance, 30-150
// [RULE10] Ground short 150, rail short 100
// [RULE11] Rail short checked once, then freeze
// [RULE12] Otherwise filtered monitoring; change slowly
// [RULE13] Temperature duty output at 9 kHz
// [RULE14] Below 25C duty about 1%
// [RULE15] 25-150C maps 3-82%, linear above
// [RULE16] Over-heat holds duty high, hysteretic release
// [RULE17] Gate falls in 5: go 1, wait positive
// [RULE18] State 2 off until negative; reset entry
// [RULE19] State 3 on; forward current goes 4
// [RULE20] State 4 locked off until gate rises
// [RULE21] Gate rise from anywhere goes state 5
// [RULE22] One assist per cycle, lockout after shoot-through
// [RULE23] Short latch held until gate low long enough
// [RULE24] Auto resume when both sensors cool
// [RULE25] Synchronise comparators and gate command; overcurrent, lockout and heat inputs are used unsynchronised
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "psw_defs.vh"

module psw_top (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [7:0]  haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // Controller side
  input  wire        gate_command_in,
  // Analog sense comparators and straps
  input  wire        supply_lockout_in,
  input  wire        gan_hot_in,
  input  wire        drv_hot_in,
  input  wire        overcurrent_in,
  input  wire        short_in,
  input  wire        drain_pos_in,
  input  wire        drain_neg_in,
  input  wire        fwd_current_in,
  input  wire        slew_open_in,
  input  wire        slew_gnd_in,
  input  wire        slew_rail_in,
  input  wire [7:0]  slew_code_in,
  input  wire [7:0]  die_temp_in,
  // Two-way alarm pin
  input  wire        current_alarm_n_in,
  // Outputs
  output reg         trouble_indicator_n_out,
  output reg         current_alarm_n_out,
  output reg         current_alarm_oe_out,
  output reg         thermal_duty_out,
  output reg         switch_on_out,
  output reg  [7:0]  slew_setting_out
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  wire gate_s   = sync2_r[0];
  wire dpos_s   = sync2_r[1];
  wire dneg_s   = sync2_r[2];
  wire fwd_s    = sync2_r[3];
  wire short_s  = sync2_r[4];
  reg  gate_d_r;
  wire gate_rise = gate_s & ~gate_d_r;
  wire gate_fall = ~gate_s & gate_d_r;

  // Two flops on each event input
  always @(posedge mclk_in) begin
    if (rst_in) begin
      sync1_r  <= 5'h00;
      sync2_r  <= 5'h00;
      gate_d_r <= 1'b0;
    end else begin
      sync1_r  <= {short_in, fwd_current_in, drain_neg_in, drain_pos_in, gate_command_in}; // RULE25
      sync2_r  <= sync1_r;
      gate_d_r <= gate_s;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        series_on_r;
  reg        combined_r;
  reg        strap_done_r;
  reg        slew_frozen_r;
  reg        short_latch_r;
  reg        hot_r;
  reg [15:0] low_cnt_r;
  reg [2:0]  de_state_r;
  reg [2:0]  de_state_nxt;
  reg        assist_used_r;

  // ----------------------------------------
  // Power-up strap capture
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (rst_in) begin
      strap_done_r  <= 1'b0;
      combined_r    <= 1'b0;
      slew_frozen_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r  <= 1'b1;
      combined_r    <= ~current_alarm_n_in; // RULE7
      slew_frozen_r <= slew_rail_in;        // RULE11
    end
  end

  // ----------------------------------------
  // Slew selection with filtering
  // ----------------------------------------
  reg [`PSW_FILT_BITS-1:0] filt_cnt_r;
  reg [7:0]                slew_raw;

  // Raw slew code from pin state
  always @* begin
    if (slew_gnd_in)
      slew_raw = `PSW_SLEW_MAX; // RULE10
    else if (slew_code_in < `PSW_SLEW_MIN)
      slew_raw = `PSW_SLEW_MIN; // RULE9
    else if (slew_code_in > `PSW_SLEW_MAX)
      slew_raw = `PSW_SLEW_MAX;
    else
      slew_raw = slew_code_in;
  end

  // Accept new code only after the raw code differs from the setting long enough
  always @(posedge mclk_in) begin
    if (rst_in) begin
      slew_setting_out <= `PSW_SLEW_MAX;
      filt_cnt_r       <= {`PSW_FILT_BITS{1'b0}};
    end else if (slew_frozen_r) begin
      slew_setting_out <= `PSW_SLEW_RAIL; // RULE10
    end else if (strap_done_r) begin
      if (slew_raw == slew_setting_out || slew_open_in)
        filt_cnt_r <= {`PSW_FILT_BITS{1'b0}};
      else if (&filt_cnt_r) begin
        slew_setting_out <= slew_raw; // RULE12
        filt_cnt_r       <= {`PSW_FILT_BITS{1'b0}};
      end else
        filt_cnt_r <= filt_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (rst_in) begin
      short_latch_r <= 1'b0;
      low_cnt_r     <= 16'h0000;
    end else begin
      if (gate_s)
        low_cnt_r <= 16'h0000;
      else if (low_cnt_r != 16'hffff)
        low_cnt_r <= low_cnt_r + 16'h0001;
      if (short_s)
        short_latch_r <= 1'b1; // RULE8
      else if (low_cnt_r >= `PSW_SHORT_RST_CYC)
        short_latch_r <= 1'b0; // RULE23
    end
  end

  // Over-heat flag, released with hysteresis
  always @(posedge mclk_in) begin
    if (rst_in)
      hot_r <= 1'b0;
    else if (gan_hot_in || drv_hot_in)
      hot_r <= 1'b1;
    else if (die_temp_in < `PSW_TEMP_HI - `PSW_HOT_HYST)
      hot_r <= 1'b0; // RULE24
  end

  // ----------------------------------------
  // Diode emulation state machine
  // ----------------------------------------
  always @* begin
    de_state_nxt = de_state_r;
    if (gate_rise)
      de_state_nxt = `PSW_DE_CMD_ON; // RULE21
    else begin
      case (de_state_r)
        `PSW_DE_CMD_ON:   if (gate_fall) de_state_nxt = `PSW_DE_WAIT_POS; // RULE17
        `PSW_DE_WAIT_POS: if (dpos_s) de_state_nxt = `PSW_DE_WAIT_NEG;
        `PSW_DE_WAIT_NEG: if (dneg_s && !assist_used_r) de_state_nxt = `PSW_DE_ASSIST; // RULE18
        `PSW_DE_ASSIST:   if (fwd_s) de_state_nxt = `PSW_DE_LOCKED; // RULE19
        `PSW_DE_LOCKED:   de_state_nxt = `PSW_DE_LOCKED; // RULE20
        default:          de_state_nxt = `PSW_DE_WAIT_NEG;
      endcase
    end
  end

  // State register and once-per-cycle assist flag
  always @(posedge mclk_in) begin
    if (rst_in || hot_r) begin
      de_state_r    <= `PSW_DE_WAIT_NEG; // RULE18
      assist_used_r <= 1'b0;
    end else begin
      de_state_r <= de_state_nxt;
      if (gate_rise)
        assist_used_r <= 1'b0;
      else if (de_state_nxt == `PSW_DE_ASSIST)
        assist_used_r <= 1'b1; // RULE22
    end
  end

  // ----------------------------------------
  // Switch drive and fault pins
  // ----------------------------------------
  wire lock_fault = supply_lockout_in | hot_r;
  wire any_trip   = lock_fault | short_latch_r | ~series_on_r;
  wire sw_want    = (de_state_r == `PSW_DE_CMD_ON) | (de_state_r == `PSW_DE_ASSIST);
  wire alarm_cond = short_latch_r | overcurrent_in; // RULE6
  wire trouble_cond = ~series_on_r | lock_fault | slew_open_in | short_latch_r | (combined_r & overcurrent_in);

  always @(posedge mclk_in) begin
    if (rst_in) begin
      switch_on_out           <= 1'b0;
      trouble_indicator_n_out <= 1'b0; // RULE2
      current_alarm_n_out     <= 1'b1;
      current_alarm_oe_out    <= 1'b0;
    end else begin
      switch_on_out           <= sw_want & ~any_trip & ~overcurrent_in & gate_s | sw_want & ~any_trip &
                                 (de_state_r == `PSW_DE_ASSIST); // RULE3
      trouble_indicator_n_out <= ~trouble_cond; // RULE1 RULE4 RULE5
      current_alarm_n_out     <= ~alarm_cond;   // RULE1
      current_alarm_oe_out    <= strap_done_r & ~combined_r; // RULE7
    end
  end

  // ----------------------------------------
  // Temperature duty output
  // ----------------------------------------
  reg [10:0]  duty_target_r;
  reg [10:0]  duty_cnt_r;
  reg [10:0]  duty_cur_r;
  reg [10:0]  pm_r;
  reg [17:0]  pm_wide;
  reg [20:0]  frac_r;
  wire [31:0] period_full = `PSW_DUTY_CYCLES;
  wire [10:0] period      = period_full[10:0]; // Period count needs eleven bits
  wire [7:0]  t_off       = die_temp_in - `PSW_TEMP_LO;
  wire [17:0] slope       = t_off * (`PSW_DUTY_HI - `PSW_DUTY_LO);
  wire [20:0] duty_div    = frac_r / 21'h0003e8;

  // Per-mille target from temperature
  always @* begin
    pm_wide = `PSW_DUTY_LO + slope / (`PSW_TEMP_HI - `PSW_TEMP_LO);
    if (die_temp_in < `PSW_TEMP_LO)
      pm_r = {1'b0, `PSW_DUTY_FLOOR}; // RULE14
    else
      pm_r = pm_wide[10:0]; // RULE15
    if (pm_r > 11'h3e8)
      pm_r = 11'h3e8;
    frac_r = pm_r[9:0] * period;
  end

  // Period counter, duty latched once per period
  always @(posedge mclk_in) begin
    if (rst_in) begin
      duty_cnt_r       <= 11'h000;
      duty_cur_r       <= 11'h000;
      duty_target_r    <= 11'h000;
      thermal_duty_out <= 1'b0;
    end else begin
      duty_target_r <= duty_div[10:0];
      if (duty_cnt_r == period - 11'h001) begin
        duty_cnt_r <= 11'h000;
        duty_cur_r <= duty_target_r; // RULE13
      end else
        duty_cnt_r <= duty_cnt_r + 11'h001;
      thermal_duty_out <= hot_r | (duty_cnt_r < duty_cur_r); // RULE16
    end
  end

  // ----------------------------------------
  // Series switch start-up control
  // ----------------------------------------
  reg [31:0] ctrl_r;
  always @(posedge mclk_in) begin
    if (rst_in)
      series_on_r <= 1'b0;
    else
      series_on_r <= ctrl_r[`PSW_CTRL_SERIES_ON] & ~supply_lockout_in;
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  reg        ph_wr_r;
  reg        ph_rd_r;
  reg [7:0]  ph_addr_r;
  wire       take = hsel_in & hready_in & htrans_in[1];
  wire [31:0] status = {24'h000000, de_state_r[0], switch_on_out, slew_frozen_r, combined_r,
                        hot_r, short_latch_r, current_alarm_n_out, trouble_indicator_n_out};

  // Address phase capture and data phase
  always @(posedge mclk_in) begin
    if (rst_in) begin
      ph_wr_r       <= 1'b0;
      ph_rd_r       <= 1'b0;
      ph_addr_r     <= 8'h00;
      ctrl_r        <= 32'h00000000;
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      ph_wr_r   <= take & hwrite_in;
      ph_rd_r   <= take & ~hwrite_in;
      ph_addr_r <= haddr_in;
      if (ph_wr_r && ph_addr_r == `PSW_ADDR_CTRL)
        ctrl_r <= {31'h00000000, hwdata_in[0]};
      if (take && !hwrite_in) begin
        case (haddr_in)
          `PSW_ADDR_CTRL:   hrdata_out <= ctrl_r;
          `PSW_ADDR_STATUS: hrdata_out <= status;
          `PSW_ADDR_SLEW:   hrdata_out <= {24'h000000, slew_setting_out};
          `PSW_ADDR_TEMP:   hrdata_out <= {21'h000000, duty_cur_r};
          default:          hrdata_out <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

//--- verification/psw_monitor.sv
`timescale 1ns/10ps
// ------------------------------
// Fault pin and diode assist checker
// ------------------------------
module psw_monitor (
  // Clock, reset and causes
  input wire mclk_in,
  input wire rst_in,
  input wire gate_command_in,
  input wire supply_lockout_in,
  input wire gan_hot_in,
  input wire overcurrent_in,
  input wire short_in,
  input wire fwd_current_in,
  // Watched outputs
  input wire trouble_indicator_n_out,
  input wire current_alarm_n_out,
  input wire current_alarm_oe_out,
  input wire thermal_duty_out,
  input wire switch_on_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Gate command edges
  sequence s_gate_rise; !gate_command_in ##1 gate_command_in; endsequence
  sequence s_gate_fall; gate_command_in ##1 !gate_command_in; endsequence
  a_lockout_trouble: assert property (supply_lockout_in [*3] |-> !trouble_indicator_n_out)
    else $error("trouble pin high during lockout");
  a_lockout_off: assert property (supply_lockout_in [*3] |-> !switch_on_out)
    else $error("switch on during lockout");
  a_alarm_low: assert property (((short_in || overcurrent_in) [*5] ##0 current_alarm_oe_out) |-> !current_alarm_n_out)
    else $error("alarm pin high on current fault");
  a_short_trouble: assert property (short_in [*6] |-> !trouble_indicator_n_out && !switch_on_out)
    else $error("short fault not reported");
  a_hot_duty: assert property (gan_hot_in [*4] |-> thermal_duty_out && !trouble_indicator_n_out)
    else $error("duty output not high on over-heat");
  a_gate_on: assert property ((s_gate_rise ##0 trouble_indicator_n_out) |-> ##[1:8] switch_on_out)
    else $error("switch not on after gate rise");
  a_gate_off: assert property (s_gate_fall |-> ##[1:8] !switch_on_out)
    else $error("switch not off after gate fall");
  a_locked_off: assert property ((fwd_current_in && !gate_command_in) [*8] |-> !switch_on_out)
    else $error("switch on while locked");
endmodule

bind psw_top psw_monitor psw_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in),
  .gate_command_in(gate_command_in), .supply_lockout_in(supply_lockout_in), .gan_hot_in(gan_hot_in),
  .overcurrent_in(overcurrent_in), .short_in(short_in), .fwd_current_in(fwd_current_in),
  .trouble_indicator_n_out(trouble_indicator_n_out), .current_alarm_n_out(current_alarm_n_out),
  .current_alarm_oe_out(current_alarm_oe_out), .thermal_duty_out(thermal_duty_out),
  .switch_on_out(switch_on_out));

//--- verification/psw_ctrl_model.sv
`timescale 1ns/10ps
// ------------------------------
// Supply controller model
// ------------------------------
module psw_ctrl_model (
  // Clock and bench requests
  input  wire mclk_in,
  input  wire gate_req_in,
  input  wire strap_gnd_in,
  // Alarm pin drive from the switch
  input  wire alarm_n_drv_in,
  input  wire alarm_oe_in,
  // Outputs to the switch
  output reg  gate_command_out,
  output wire alarm_pin_n_out
);
  initial gate_command_out = 1'h0;
  // Gate command launched one edge after the request
  always @(posedge mclk_in) begin
    gate_command_out <= gate_req_in;
  end
  // Strap to ground wins, else switch drive, else pull-up
  assign alarm_pin_n_out = strap_gnd_in ? 1'h0 : (alarm_oe_in ? alarm_n_drv_in : 1'h1);
endmodule

//--- verification/test_psw_top.sv
`timescale 1ns/10ps
`include "psw_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
// ------------------------------
// Bench for the power switch block
// ------------------------------
module test_psw_top;
  logic        mclk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, gate_req = 1'h0, strap_gnd = 1'h0;
  logic        lock = 1'h0, ghot = 1'h0, dhot = 1'h0, ovc = 1'h0, shrt = 1'h0, dpos = 1'h0, dneg = 1'h0;
  logic        fwd = 1'h0, sopen = 1'h0, sgnd = 1'h0, srail = 1'h0;
  logic [7:0]  haddr = 8'h00, slew_code = 8'h96, die_temp = 8'h1e;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd;
  logic [7:0]  tmp [3] = '{8'h0a, `PSW_TEMP_LO, `PSW_TEMP_HI};
  logic [9:0]  pm [3] = '{`PSW_DUTY_FLOOR, `PSW_DUTY_LO, `PSW_DUTY_HI};
  wire  [31:0] hrdata;
  wire  [7:0]  slew;
  wire         hready, hresp, gate, alarm_pin_n, trb_n, alm_n, alm_oe, duty, sw;
  int          n_mismatch = 0, n_checks = 0, hi, e;

  psw_top psw_top_inst (.mclk_in(mclk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .gate_command_in(gate), .supply_lockout_in(lock),
    .gan_hot_in(ghot), .drv_hot_in(dhot), .overcurrent_in(ovc), .short_in(shrt), .drain_pos_in(dpos),
    .drain_neg_in(dneg), .fwd_current_in(fwd), .slew_open_in(sopen), .slew_gnd_in(sgnd),
    .slew_rail_in(srail), .slew_code_in(slew_code), .die_temp_in(die_temp),
    .current_alarm_n_in(alarm_pin_n), .trouble_indicator_n_out(trb_n), .current_alarm_n_out(alm_n),
    .current_alarm_oe_out(alm_oe), .thermal_duty_out(duty), .switch_on_out(sw), .slew_setting_out(slew));
  psw_ctrl_model psw_ctrl_model_inst (.mclk_in(mclk), .gate_req_in(gate_req), .strap_gnd_in(strap_gnd),
    .alarm_n_drv_in(alm_n), .alarm_oe_in(alm_oe), .gate_command_out(gate), .alarm_pin_n_out(alarm_pin_n));

  // Clock, 100 ns period
  always #50 mclk = ~mclk;

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One single-word bus transfer, waits on ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic set_f(input int i, input logic v);
    case (i)
      0: lock <= v;
      1: ghot <= v;
      2: sopen <= v;
      default: ovc <= v;
    endcase
  endtask
  // Positive then negative drain swing
  task automatic pn;
    dneg <= 1'h0;
    dpos <= 1'h1;
    w(6);
    dpos <= 1'h0;
    dneg <= 1'h1;
    w(8);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    w(6);
    rst <= 1'h0;
    w(2);
    `CHK("trouble at start", 1'h0, trb_n)
    ahb(1'h0, `PSW_ADDR_STATUS, 32'h0);
    `CHK("status trouble", 1'h0, rd[`PSW_ST_TROUBLE])
    ahb(1'h0, 8'h10, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("bus response", 1'h0, hresp)
    ahb(1'h1, `PSW_ADDR_CTRL, 32'h1);
    w(4);
    `CHK("trouble after start", 1'h1, trb_n)
    `CHK("alarm driven", 1'h1, alm_oe)
    for (int i = 0; i < 4; i++) begin
      set_f(i, 1'h1);
      w(8);
      `CHK("trouble pin", i == 3, trb_n)
      `CHK("alarm pin", i != 3, alm_n)
      if (i == 1) `CHK("duty on heat", 1'h1, duty)
      set_f(i, 1'h0);
      w(8);
      `CHK("trouble cleared", 1'h1, trb_n)
    end
    gate_req <= 1'h1;
    w(10);
    `CHK("switch on command", 1'h1, sw)
    gate_req <= 1'h0;
    dneg <= 1'h1;
    w(10);
    `CHK("no assist before positive", 1'h0, sw)
    pn();
    `CHK("assist on", 1'h1, sw)
    fwd <= 1'h1;
    w(8);
    `CHK("locked off", 1'h0, sw)
    fwd <= 1'h0;
    pn();
    `CHK("one assist per cycle", 1'h0, sw)
    dneg <= 1'h0;
    gate_req <= 1'h1;
    w(10);
    `CHK("gate rise unlocks", 1'h1, sw)
    shrt <= 1'h1;
    w(8);
    shrt <= 1'h0;
    w(20);
    `CHK("short trouble", 1'h0, trb_n)
    `CHK("short alarm", 1'h0, alm_n)
    `CHK("short switch", 1'h0, sw)
    gate_req <= 1'h0;
    w(2100);
    `CHK("short released", 1'h1, trb_n)
    gate_req <= 1'h1;
    w(10);
    `CHK("switch after release", 1'h1, sw)
    slew_code <= `PSW_SLEW_MIN;
    w(80);
    `CHK("slew from code", `PSW_SLEW_MIN, slew)
    sgnd <= 1'h1;
    w(80);
    `CHK("slew ground", `PSW_SLEW_MAX, slew)
    sgnd <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      die_temp <= tmp[i];
      w(1200);
      hi = 0;
      repeat (`PSW_DUTY_CYCLES) begin
        @(posedge mclk);
        hi += duty;
      end
      e = `PSW_DUTY_CYCLES * pm[i] / 1000;
      `CHK("duty count", 1'h1, hi >= e - 8 && hi <= e + 8)
    end
    rst <= 1'h1;
    strap_gnd <= 1'h1;
    srail <= 1'h1;
    w(6);
    rst <= 1'h0;
    w(4);
    `CHK("rail slew", `PSW_SLEW_RAIL, slew)
    ahb(1'h1, `PSW_ADDR_CTRL, 32'h1);
    slew_code <= 8'h50;
    w(80);
    `CHK("slew frozen", `PSW_SLEW_RAIL, slew)
    ovc <= 1'h1;
    w(8);
    `CHK("combined trouble", 1'h0, trb_n)
    `CHK("alarm not driven", 1'h0, alm_oe)
    ovc <= 1'h0;
    w(8);
    `CHK("combined normal", 1'h1, trb_n)
    end_of_test();
  end

  // Watchdog against a hung run
  initial begin
    w(20000);
    n_mismatch++;
    end_of_test();
  end
endmodule
